// ---- src/pcrs_pkg.sv ----
// shared constants and carrier types of the program counter and return stack
package pcrs_pkg;

  localparam int unsigned PC_W       = 21;
  localparam int unsigned SP_W       = 5;
  localparam int unsigned WORD_W     = 16;
  localparam logic [4:0]  STK_DEPTH  = 5'h1f;
  localparam logic [20:0] PC_STEP    = 21'h000002;

  // fetch vectors
  localparam logic [20:0] RESET_VEC  = 21'h000000;
  localparam logic [20:0] INT_VEC_HI = 21'h000008;
  localparam logic [20:0] INT_VEC_LO = 21'h000018;

  // implemented program memory, bytes; fetches above it return zero
  localparam logic [20:0] PROG_TOP   = 21'h008000;

  // register word indices on the bus, byte address is index times four
  localparam logic [5:0] IDX_STACK_PTR = 6'h00;
  localparam logic [5:0] IDX_TOP_LOW   = 6'h01;
  localparam logic [5:0] IDX_TOP_HIGH  = 6'h02;
  localparam logic [5:0] IDX_TOP_UPPER = 6'h03;
  localparam logic [5:0] IDX_PC_LOW    = 6'h04;
  localparam logic [5:0] IDX_HIGH_LAT  = 6'h05;
  localparam logic [5:0] IDX_UPPER_LAT = 6'h06;
  localparam logic [5:0] IDX_OPTION    = 6'h07;

  // return_stack_pointer_status field positions
  localparam int unsigned FULL_BIT = 7;
  localparam int unsigned UNF_BIT  = 6;

  // reset values
  localparam logic [4:0] SP_RST     = 5'h00;
  localparam logic [7:0] LAT_RST    = 8'h00;
  localparam logic       OPTION_RST = 1'b1;

  typedef enum logic [3:0] {
    OP_IDLE,
    OP_SEQ,
    OP_JUMP,
    OP_CALL,
    OP_RET,
    OP_PUSH,
    OP_POP,
    OP_INT,
    OP_PC_LOW_WR,
    OP_PC_LOW_RD
  } pcrs_op_t;

  typedef struct packed {
    logic [7:0] status;
    logic [7:0] working_register;
    logic [7:0] bank_select_register;
  } pcrs_shadow_t;

  typedef struct packed {
    pcrs_op_t     op;
    logic         fast;
    logic         vec_high;
    logic [7:0]   data;
    logic [20:0]  target;
    pcrs_shadow_t regs;
  } pcrs_cmd_t;

endpackage : pcrs_pkg

// ---- src/pcrs_core.sv ----
// program counter, return stack, fast shadow and their register slave
`timescale 1ns/1ps

// Overview of operation
// - program counter is 21 bits wide and holds a byte address.
// - fetches above implemented memory, up to 2 Mbyte, return all zeros.
// - reset vector at 0000h, interrupt vectors at 0008h and 0018h.
// - counter in three bytes; only low byte accessed, upper two through latches.
// - any low-byte write loads bits 20:8 from the two holding latches.
// - any low-byte read copies bits 20:8 into the two holding latches.
// - bit 0 always zero; sequential instructions advance the counter by two.
// - call, relative call and jump load the counter directly, latches unused.
// - calls and interrupts push, returns pop, up to 31 nested levels.
// - calls and returns without a stack fault leave both holding latches unchanged.
// - stack is 31 entries of 21 bits with a 5-bit pointer.
// - push increments pointer first, then stores next-instruction address there.
// - pop loads counter from selected entry, then decrements pointer.
// - every reset clears pointer; value zero has no entry, only empty.
// - top entry registers read and write the entry the pointer selects.
// - full flag set after 31 pushes; cleared only by software or power-on.
// - with fault option, 31st push stores, sets full, resets, pointer zero.
// - without option, pointer stays 31; further pushes neither write nor move.
// - pop at zero loads zero, sets underflow, pointer stays zero.
// - with option a full or underflow also resets; without only flags.
// - push instruction stores next-instruction address; pop instruction only drops the top entry.
// - one-deep shadow captured on interrupt or fast call, restored on fast return.
module pcrs_core (
  input  wire logic                clk,
  input  wire logic                nrst,
  input  wire pcrs_pkg::pcrs_cmd_t cmd,
  input  wire logic [15:0]         prog_rdata,
  output logic [20:0]              pc,
  output logic [15:0]              fetch_word,
  output logic                     restore_valid,
  output pcrs_pkg::pcrs_shadow_t   restore_regs,
  output logic                     fault_reset,
  input  wire logic [7:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  input  wire logic [3:0]          avs_byteenable,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest
);
  import pcrs_pkg::*;

  logic              rst_meta_q;
  logic              rst_n_q;
  logic [20:0]       pc_q;
  logic [20:0]       pc_d;
  logic [4:0]        sp_q;
  logic [4:0]        sp_d;
  logic [20:0]       stk_q [1:31];
  logic [7:0]        lat_h_q;
  logic [4:0]        lat_u_q;
  logic              full_q;
  logic              unf_q;
  logic              option_q;
  pcrs_shadow_t      shadow_q;
  pcrs_shadow_t      restore_q;
  logic              restore_valid_q;
  logic              fault_q;
  logic [15:0]       fetch_q;
  logic              wait_q;
  logic [31:0]       rdata_q;
  logic              push_we;
  logic [4:0]        push_idx;
  logic [20:0]       top_val;
  logic              set_full;
  logic              set_unf;
  logic              fault;
  logic              cap_lat;
  logic              shadow_cap;
  logic              restore;
  logic              sw_acc;
  logic              sw_wr;
  logic [5:0]        sw_idx;
  logic [7:0]        sw_byte;

  // reset release through two flops
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // bus access completes on the edge where waitrequest is low
  assign sw_acc  = (avs_read | avs_write) & ~wait_q;
  assign sw_wr   = sw_acc & avs_write & avs_byteenable[0];
  assign sw_idx  = avs_address[7:2];
  assign sw_byte = avs_writedata[7:0];
  assign top_val = (sp_q == SP_RST) ? 21'h000000 : stk_q[sp_q];

  always_comb begin
    pc_d       = pc_q;
    sp_d       = sp_q;
    push_we    = 1'b0;
    push_idx   = 5'(sp_q + 5'h01);
    set_full   = 1'b0;
    set_unf    = 1'b0;
    fault      = 1'b0;
    cap_lat    = 1'b0;
    shadow_cap = 1'b0;
    restore    = 1'b0;
    case (cmd.op)
      OP_SEQ: begin
        pc_d = pc_q + PC_STEP;
      end
      OP_JUMP: begin
        pc_d = {cmd.target[20:1], 1'b0};
      end
      OP_CALL, OP_INT, OP_PUSH: begin
        if (sp_q == STK_DEPTH) begin
          set_full = 1'b1;
          fault    = option_q;
        end else begin
          sp_d    = push_idx;
          push_we = 1'b1;
          if (push_idx == STK_DEPTH) begin
            set_full = 1'b1;
            fault    = option_q;
          end
        end
        if (cmd.op == OP_CALL) begin
          pc_d = {cmd.target[20:1], 1'b0};
        end else if (cmd.op == OP_INT) begin
          pc_d = cmd.vec_high ? INT_VEC_HI : INT_VEC_LO;
        end else begin
          pc_d = pc_q + PC_STEP;
        end
        shadow_cap = (cmd.op == OP_INT) | ((cmd.op == OP_CALL) & cmd.fast);
      end
      OP_RET: begin
        if (sp_q == SP_RST) begin
          pc_d    = RESET_VEC;
          set_unf = 1'b1;
          fault   = option_q;
        end else begin
          // software may leave bit 0 set in the top entry
          pc_d = {top_val[20:1], 1'b0};
          sp_d = 5'(sp_q - 5'h01);
        end
        restore = cmd.fast;
      end
      OP_POP: begin
        if (sp_q == SP_RST) begin
          set_unf = 1'b1;
          fault   = option_q;
        end else begin
          sp_d = 5'(sp_q - 5'h01);
        end
        pc_d = pc_q + PC_STEP;
      end
      OP_PC_LOW_WR: begin
        pc_d = {lat_u_q, lat_h_q, cmd.data[7:1], 1'b0};
      end
      OP_PC_LOW_RD: begin
        cap_lat = 1'b1;
        pc_d    = pc_q + PC_STEP;
      end
      default: begin
      end
    endcase
    // software access lands after the core step in the same cycle
    if (sw_wr && sw_idx == IDX_PC_LOW) begin
      pc_d = {lat_u_q, lat_h_q, sw_byte[7:1], 1'b0};
    end
    if (sw_acc && avs_read && sw_idx == IDX_PC_LOW) begin
      cap_lat = 1'b1;
    end
    if (sw_wr && sw_idx == IDX_STACK_PTR) begin
      sp_d = sw_byte[4:0];
    end
    if (fault) begin
      pc_d = RESET_VEC;
      sp_d = SP_RST;
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pc_q <= RESET_VEC;
      sp_q <= SP_RST;
    end else begin
      pc_q <= pc_d;
      sp_q <= sp_d;
    end
  end

  // one flop per entry; pointer zero owns no storage
  for (genvar i = 1; i <= 31; i++) begin : g_entry
    always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
        stk_q[i] <= 21'h000000;
      end else if (push_we && push_idx == 5'(i)) begin
        stk_q[i] <= pc_q + PC_STEP;
      end else if (sw_wr && sp_q == 5'(i)) begin
        if (sw_idx == IDX_TOP_LOW) begin
          stk_q[i][7:0] <= sw_byte;
        end else if (sw_idx == IDX_TOP_HIGH) begin
          stk_q[i][15:8] <= sw_byte;
        end else if (sw_idx == IDX_TOP_UPPER) begin
          stk_q[i][20:16] <= sw_byte[4:0];
        end
      end
    end
  end

  // holding latches; a stack fault is a device reset and clears them
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      lat_h_q <= LAT_RST;
      lat_u_q <= LAT_RST[4:0];
    end else if (fault) begin
      lat_h_q <= LAT_RST;
      lat_u_q <= LAT_RST[4:0];
    end else if (cap_lat) begin
      lat_h_q <= pc_q[15:8];
      lat_u_q <= pc_q[20:16];
    end else if (sw_wr && sw_idx == IDX_HIGH_LAT) begin
      lat_h_q <= sw_byte;
    end else if (sw_wr && sw_idx == IDX_UPPER_LAT) begin
      lat_u_q <= sw_byte[4:0];
    end
  end

  // flags: set wins over a software clear, fault reset keeps them
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      full_q <= 1'b0;
      unf_q  <= 1'b0;
    end else begin
      if (set_full) begin
        full_q <= 1'b1;
      end else if (sw_wr && sw_idx == IDX_STACK_PTR && !sw_byte[FULL_BIT]) begin
        full_q <= 1'b0;
      end
      if (set_unf) begin
        unf_q <= 1'b1;
      end else if (sw_wr && sw_idx == IDX_STACK_PTR && !sw_byte[UNF_BIT]) begin
        unf_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      option_q <= OPTION_RST;
    end else if (sw_wr && sw_idx == IDX_OPTION) begin
      option_q <= sw_byte[0];
    end
  end

  // shadow is write-only from the core, never visible on the bus
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      shadow_q        <= '0;
      restore_q       <= '0;
      restore_valid_q <= 1'b0;
    end else begin
      if (shadow_cap) begin
        shadow_q <= cmd.regs;
      end
      restore_valid_q <= restore;
      if (restore) begin
        restore_q <= shadow_q;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      fault_q <= 1'b0;
      fetch_q <= 16'h0000;
    end else begin
      fault_q <= fault;
      fetch_q <= (pc_q >= PROG_TOP) ? 16'h0000 : prog_rdata;
    end
  end

  // one wait state: data is prepared while waitrequest is high
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      wait_q <= ~((avs_read | avs_write) & wait_q);
      if (avs_read && wait_q) begin
        case (sw_idx)
          IDX_STACK_PTR: rdata_q <= {24'h000000, full_q, unf_q, 1'b0, sp_q};
          IDX_TOP_LOW:   rdata_q <= {24'h000000, top_val[7:0]};
          IDX_TOP_HIGH:  rdata_q <= {24'h000000, top_val[15:8]};
          IDX_TOP_UPPER: rdata_q <= {27'h0000000, top_val[20:16]};
          IDX_PC_LOW:    rdata_q <= {24'h000000, pc_q[7:0]};
          IDX_HIGH_LAT:  rdata_q <= {24'h000000, lat_h_q};
          IDX_UPPER_LAT: rdata_q <= {27'h0000000, lat_u_q};
          IDX_OPTION:    rdata_q <= {31'h00000000, option_q};
          default:       rdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  assign pc              = pc_q;
  assign fetch_word      = fetch_q;
  assign restore_valid   = restore_valid_q;
  assign restore_regs    = restore_q;
  assign fault_reset     = fault_q;
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;

  property p_lsb_zero;
    @(posedge clk) disable iff (!rst_n_q) pc_q[0] == 1'b0;
  endproperty
  a_lsb_zero: assert property (p_lsb_zero) else $error("pc bit 0 set");

  property p_seq_step;
    @(posedge clk) disable iff (!rst_n_q)
      (cmd.op == OP_SEQ && !sw_wr) |=> pc_q == $past(pc_q) + PC_STEP;
  endproperty
  a_seq_step: assert property (p_seq_step) else $error("no step of two");

  property p_sp_range;
    @(posedge clk) disable iff (!rst_n_q) push_we |-> push_idx != SP_RST;
  endproperty
  a_sp_range: assert property (p_sp_range) else $error("push wrapped past 31");

  property p_push_store;
    @(posedge clk) disable iff (!rst_n_q)
      (cmd.op == OP_CALL && sp_q < 5'h1e && !sw_wr)
      |=> sp_q == $past(sp_q) + 5'h01 && stk_q[sp_q] == $past(pc_q) + PC_STEP;
  endproperty
  a_push_store: assert property (p_push_store) else $error("push wrong");

  property p_pop_load;
    @(posedge clk) disable iff (!rst_n_q)
      (cmd.op == OP_RET && sp_q != 5'h00 && !sw_wr)
      |=> pc_q == {$past(top_val[20:1]), 1'b0} && sp_q == $past(sp_q) - 5'h01;
  endproperty
  a_pop_load: assert property (p_pop_load) else $error("pop wrong");

  property p_underflow;
    @(posedge clk) disable iff (!rst_n_q)
      (cmd.op == OP_RET && sp_q == 5'h00 && !sw_wr) |=> pc_q == 21'h0 && unf_q && sp_q == 5'h00;
  endproperty
  a_underflow: assert property (p_underflow) else $error("underflow wrong");

  property p_fault_reset;
    @(posedge clk) disable iff (!rst_n_q)
      (cmd.op == OP_CALL && sp_q == 5'h1e && option_q)
      |=> full_q && sp_q == 5'h00 && pc_q == RESET_VEC && fault_reset;
  endproperty
  a_fault_reset: assert property (p_fault_reset) else $error("fault reset wrong");

  property p_full_hold;
    @(posedge clk) disable iff (!rst_n_q)
      (cmd.op == OP_CALL && sp_q == 5'h1f && !option_q && !sw_wr)
      |=> sp_q == 5'h1f && $stable(stk_q[31]) && full_q;
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("overflow moved");

  property p_pc_low_write;
    @(posedge clk) disable iff (!rst_n_q)
      (cmd.op == OP_PC_LOW_WR && !sw_wr) |=> pc_q[20:8] == {$past(lat_u_q), $past(lat_h_q)};
  endproperty
  a_pc_low_write: assert property (p_pc_low_write) else $error("latch not moved");

  property p_int_vector;
    @(posedge clk) disable iff (!rst_n_q)
      (cmd.op == OP_INT && sp_q < 5'h1e && !sw_wr)
      |=> pc_q == ($past(cmd.vec_high) ? INT_VEC_HI : INT_VEC_LO);
  endproperty
  a_int_vector: assert property (p_int_vector) else $error("bad vector");

  property p_call_latch;
    @(posedge clk) disable iff (!rst_n_q)
      (cmd.op inside {OP_CALL, OP_RET} && !sw_wr && !fault)
      |=> $stable(lat_h_q) && $stable(lat_u_q);
  endproperty
  a_call_latch: assert property (p_call_latch) else $error("latch disturbed");

endmodule : pcrs_core

// ---- tb/pcrs_prog_mem.sv ----
// program memory model that feeds the core one word for every address
`timescale 1ns/1ps
module pcrs_prog_mem (
  input  wire logic [20:0] pc,
  output logic      [15:0] prog_rdata
);
  // answers past the implemented top too, so zeroing is left to the core
  assign prog_rdata = {pc[15:1], 1'b1} ^ 16'ha5c3;
endmodule : pcrs_prog_mem

// ---- tb/program_counter_return_stack_test.sv ----
// self-checking bench of the program counter and return stack
`timescale 1ns/1ps
module program_counter_return_stack_test;
  import pcrs_pkg::*;
  typedef struct packed {
    pcrs_op_t    op;
    logic [1:0]  fv;
    logic [7:0]  d;
    logic [20:0] tgt;
    logic [20:0] pc;
  } pcrs_row_t;
  logic         clk;
  logic         nrst;
  pcrs_cmd_t    cmd;
  logic [15:0]  prog_rdata;
  logic [15:0]  fetch_word;
  logic [20:0]  pc;
  logic         restore_valid;
  logic         fault_reset;
  pcrs_shadow_t restore_regs;
  pcrs_shadow_t last_regs;
  logic [7:0]   avs_address;
  logic         avs_read;
  logic         avs_write;
  logic [31:0]  avs_writedata;
  logic [3:0]   avs_byteenable;
  logic [31:0]  avs_readdata;
  logic         avs_waitrequest;
  int           n_fail = 0;
  int           checks_done = 0;
  int           n_fault = 0;
  int           n_rest = 0;
  pcrs_row_t    rows[13];

  pcrs_core dut_u (.clk(clk), .nrst(nrst), .cmd(cmd), .prog_rdata(prog_rdata), .pc(pc),
    .fetch_word(fetch_word), .restore_valid(restore_valid), .restore_regs(restore_regs),
    .fault_reset(fault_reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  pcrs_prog_mem mem_u (.pc(pc), .prog_rdata(prog_rdata));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // pulses last one cycle, so count them instead of sampling them late
  always @(posedge clk) begin
    if (fault_reset === 1'b1) n_fault <= n_fault + 1;
    if (restore_valid === 1'b1) begin
      n_rest <= n_rest + 1;
      last_regs <= restore_regs;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      n_fail++;
      end_of_test();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    #1;
  endtask : bus

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr

  task automatic rd(input logic [5:0] idx, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk(q, {24'h0, e});
  endtask : rd

  task automatic step(input pcrs_op_t op, input logic [1:0] fv, input logic [7:0] d,
                      input logic [20:0] tgt);
    @(posedge clk);
    cmd.op <= op;
    cmd.fast <= fv[1];
    cmd.vec_high <= fv[0];
    cmd.data <= d;
    cmd.target <= tgt;
    @(posedge clk);
    cmd.op <= OP_IDLE;
    #1;
  endtask : step

  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    end_of_test();
  end

  initial begin
    nrst = 1'b0;
    cmd = '0;
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    rows = '{'{OP_SEQ, 2'b00, 8'h00, 21'h0, 21'h000002},
             '{OP_SEQ, 2'b00, 8'h00, 21'h0, 21'h000004},
             '{OP_JUMP, 2'b00, 8'h00, 21'h1f0100, 21'h1f0100},
             '{OP_CALL, 2'b00, 8'h00, 21'h000200, 21'h000200},
             '{OP_INT, 2'b01, 8'h00, 21'h0, 21'h000008},
             '{OP_RET, 2'b00, 8'h00, 21'h0, 21'h000202},
             '{OP_RET, 2'b00, 8'h00, 21'h0, 21'h1f0102},
             '{OP_INT, 2'b00, 8'h00, 21'h0, 21'h000018},
             '{OP_RET, 2'b00, 8'h00, 21'h0, 21'h1f0104},
             '{OP_PUSH, 2'b00, 8'h00, 21'h0, 21'h1f0106},
             '{OP_POP, 2'b00, 8'h00, 21'h0, 21'h1f0108},
             '{OP_PC_LOW_RD, 2'b00, 8'h00, 21'h0, 21'h1f010a},
             '{OP_PC_LOW_WR, 2'b00, 8'h35, 21'h0, 21'h1f0134}};
    repeat (12) @(posedge clk);
    chk({11'h0, pc}, 32'h0);
    chk({31'h0, avs_waitrequest}, 32'h1);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd(IDX_STACK_PTR, 8'h00);
    rd(IDX_OPTION, 8'h01);
    // stack registers are touched only while no interrupt op is issued
    foreach (rows[i]) begin
      step(rows[i].op, rows[i].fv, rows[i].d, rows[i].tgt);
      chk({11'h0, pc}, {11'h0, rows[i].pc});
      @(posedge clk);
      #1;
      chk({16'h0, fetch_word}, pc < PROG_TOP ? {16'h0, {pc[15:1], 1'b1} ^ 16'ha5c3} : 0);
    end
    step(OP_CALL, 2'b00, 8'h00, 21'h000040);
    step(OP_RET, 2'b00, 8'h00, 21'h0);
    rd(IDX_HIGH_LAT, 8'h01);
    rd(IDX_UPPER_LAT, 8'h1f);
    wr(IDX_HIGH_LAT, 8'h12);
    wr(IDX_UPPER_LAT, 8'h03);
    wr(IDX_PC_LOW, 8'h57);
    chk({11'h0, pc}, 32'h031256);
    rd(IDX_PC_LOW, 8'h56);
    step(OP_CALL, 2'b00, 8'h00, 21'h000040);
    rd(IDX_TOP_LOW, 8'h58);
    rd(IDX_TOP_HIGH, 8'h12);
    rd(IDX_TOP_UPPER, 8'h03);
    wr(IDX_TOP_LOW, 8'h81);
    step(OP_RET, 2'b00, 8'h00, 21'h0);
    chk({11'h0, pc}, 32'h031280);
    rd(IDX_STACK_PTR, 8'h00);
    // underflow and full without the fault option: flags only
    wr(IDX_OPTION, 8'h00);
    step(OP_RET, 2'b00, 8'h00, 21'h0);
    chk({11'h0, pc}, 32'h0);
    rd(IDX_STACK_PTR, 8'h40);
    wr(IDX_STACK_PTR, 8'h00);
    for (int i = 0; i < 31; i++) begin
      step(OP_CALL, 2'b00, 8'h00, 21'h000100);
      if (i == 29) rd(IDX_STACK_PTR, 8'h1e);
    end
    rd(IDX_STACK_PTR, 8'h9f);
    step(OP_JUMP, 2'b00, 8'h00, 21'h000500);
    step(OP_CALL, 2'b00, 8'h00, 21'h000300);
    rd(IDX_STACK_PTR, 8'h9f);
    rd(IDX_TOP_LOW, 8'h02);
    chk(n_fault, 0);
    // fault option on: the 31st push and an underflow both reset
    wr(IDX_OPTION, 8'h01);
    wr(IDX_STACK_PTR, 8'h1e);
    step(OP_CALL, 2'b00, 8'h00, 21'h000100);
    chk({11'h0, pc}, 32'h0);
    rd(IDX_STACK_PTR, 8'h80);
    rd(IDX_HIGH_LAT, 8'h00);
    chk(n_fault, 1);
    step(OP_RET, 2'b00, 8'h00, 21'h0);
    rd(IDX_STACK_PTR, 8'hc0);
    chk(n_fault, 2);
    // shadow captured at vectoring and fast call, restored on fast return
    @(posedge clk) cmd.regs <= 24'h445566;
    step(OP_INT, 2'b01, 8'h00, 21'h0);
    @(posedge clk) cmd.regs <= 24'h000000;
    step(OP_RET, 2'b10, 8'h00, 21'h0);
    repeat (2) @(posedge clk);
    chk({8'h0, last_regs}, 32'h445566);
    @(posedge clk) cmd.regs <= 24'h778899;
    step(OP_CALL, 2'b10, 8'h00, 21'h000040);
    @(posedge clk) cmd.regs <= 24'h000000;
    step(OP_RET, 2'b10, 8'h00, 21'h0);
    repeat (2) @(posedge clk);
    chk({8'h0, last_regs}, 32'h778899);
    chk(n_rest, 2);
    // mid-run power-on reset: pointer, flags and option back to reset values
    wr(IDX_STACK_PTR, 8'hc5);
    rd(IDX_STACK_PTR, 8'hc5);
    @(posedge clk) nrst <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk({11'h0, pc}, 32'h0);
    @(posedge clk) nrst <= 1'b1;
    repeat (3) @(posedge clk);
    rd(IDX_STACK_PTR, 8'h00);
    rd(IDX_OPTION, 8'h01);
    end_of_test();
  end
endmodule : program_counter_return_stack_test
